// [rtl/csp_top.sv]
/*
 Strobe, PWM, two general-purpose pins and a two-colour lamp.
 Assumes exposure start and end arrive as one-cycle pulses on the same clock.
*/
//Contract
// - Zero strobe length keeps strobe active until exposure ends; with global start shutter the code ends it at first row end instead.
// - Delay is signed microseconds, length unsigned microseconds.
// - PWM frequency programmable from 1 Hz to 10000 Hz.
// - PWM duty 0.0 to 1.0, full means always high.
// - PWM mode routes PWM waveform onto the strobe output.
// - PWM routing can place PWM on pin 1 or pin 2.
// - Report PWM-capable pins and PWM current, min, max, increment values.
// - Lamp has orange and green states, current state readable.
// - Toggle command swaps the lamp to the other colour.
// - Selected pin returns capability mask of input or output.
// - Configuration write sets pin mode; read returns current mode.
// - Pin level reads 0 low, 1 high; writes drive low or high.
// - Constant modes hold strobe static high or low.
// - High-active and low-active pulse modes in trigger and freerun.
module csp_top
   import csp_pkg::*;
(
   // Clock and reset
   input  wire logic             ref_clk_in,
   input  wire logic             sys_rst_in,
   // Exposure timing
   input  wire logic             expo_start_in,
   input  wire logic             expo_end_in,
   input  wire logic             first_row_end_in,
   input  wire logic             global_start_shutter_in,
   input  wire logic             trigger_mode_in,
   // Strobe settings
   input  wire csp_pkg::csp_strobe_mode_t strobe_mode_in,
   input  wire logic signed [31:0] strobe_delay_us_in,
   input  wire logic [31:0]      strobe_length_us_in,
   // PWM settings
   input  wire logic [31:0]      pwm_frequency_in,
   input  wire logic [15:0]      pwm_duty_in,
   input  wire logic [1:0]       set_pwm_routing_in,
   // Pin configuration
   input  wire logic             pin_select_in,
   input  wire logic             pin_cfg_wr_in,
   input  wire logic             pin_direction_cfg_in,
   input  wire logic             pin_level_in,
   input  wire logic [1:0]       gpio_pin_in,
   // Lamp
   input  wire logic             lamp_set_in,
   input  wire logic             lamp_green_in,
   input  wire logic             lamp_toggle_cmd_in,
   // Strobe and pins
   output logic                  strobe_out,
   output logic [1:0]            gpio_pin_out,
   output logic [1:0]            gpio_pin_oe_out,
   // Readback
   output logic [1:0]            pin_capability_mask_out,
   output logic                  pin_direction_cfg_out,
   output logic                  pin_level_out,
   output logic [1:0]            pwm_pin_caps_out,
   output logic [31:0]           pwm_freq_cur_out,
   output logic [31:0]           pwm_freq_min_out,
   output logic [31:0]           pwm_freq_max_out,
   output logic [31:0]           pwm_freq_inc_out,
   output logic [15:0]           pwm_duty_cur_out,
   output logic [15:0]           pwm_duty_min_out,
   output logic [15:0]           pwm_duty_max_out,
   output logic [15:0]           pwm_duty_inc_out,
   output logic [1:0]            pwm_routing_out,
   output logic                  lamp_green_out,
   output logic                  lamp_orange_out
);
   import csp_pkg::*;

   logic [7:0]     div_q;
   logic           tick_us;
   csp_stb_state_t st_q;
   csp_stb_state_t st_d;
   logic [31:0]    cnt_q;
   logic [31:0]    cnt_d;
   logic           pwm_wave;
   logic [1:0]     dir_q;
   logic [1:0]     lvl_q;
   logic           lamp_q;
   logic           pulse_on;
   logic           mode_ok;
   logic           mode_hi;
   logic           len_zero;
   logic           end_evt;
   logic [31:0]    delay_mag;
   logic           strobe_d;
   logic [1:0]     pin_drv;
   logic           sel_dir;
   logic           sel_lvl;

   // Microsecond tick
   assign tick_us = (div_q == TICK_DIV_LAST);

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in || tick_us) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   csp_pwm u_pwm (
      .ref_clk_in (ref_clk_in),
      .sys_rst_in (sys_rst_in),
      .freq_hz_in (pwm_frequency_in),
      .duty_in    (pwm_duty_in),
      .pwm_out    (pwm_wave)
   );

   // Strobe mode decode
   assign mode_ok  = trigger_mode_in ? (strobe_mode_in == STB_TRIG_HI || strobe_mode_in == STB_TRIG_LO)
                                     : (strobe_mode_in == STB_FREE_HI || strobe_mode_in == STB_FREE_LO);
   assign mode_hi  = (strobe_mode_in == STB_TRIG_HI) || (strobe_mode_in == STB_FREE_HI);
   assign len_zero = (strobe_length_us_in == 32'h0);
   assign end_evt  = global_start_shutter_in ? first_row_end_in : expo_end_in;
   // Negative delay clamped to immediate start
   assign delay_mag = strobe_delay_us_in[31] ? 32'h0 : strobe_delay_us_in;

   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      case (st_q)
         ST_IDLE: begin
            if (expo_start_in && mode_ok) begin
               cnt_d = delay_mag;
               st_d  = (delay_mag == 32'h0) ? ST_PULSE : ST_DELAY;
               if (delay_mag == 32'h0) begin
                  cnt_d = strobe_length_us_in;
               end
            end
         end
         ST_DELAY: begin
            if (!mode_ok) begin
               st_d = ST_IDLE;
            end else if (tick_us) begin
               // Extra tick so the full delay elapses whatever the tick phase
               cnt_d = cnt_q - 32'h1;
               if (cnt_q == 32'h0) begin
                  st_d  = ST_PULSE;
                  cnt_d = strobe_length_us_in;
               end
            end
         end
         ST_PULSE: begin
            if (!mode_ok) begin
               st_d = ST_IDLE;
            end else if (len_zero) begin
               if (end_evt) begin
                  st_d = ST_IDLE;
               end
            end else if (tick_us) begin
               cnt_d = cnt_q - 32'h1;
               if (cnt_q <= 32'h1) begin
                  st_d = ST_IDLE;
               end
            end
         end
         default: begin
            st_d  = ST_IDLE;
            cnt_d = 32'h0;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         st_q  <= ST_IDLE;
         cnt_q <= 32'h0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end

   assign pulse_on = (st_q == ST_PULSE);

   // Strobe output select
   always_comb begin
      case (strobe_mode_in)
         STB_CONST_HI: strobe_d = 1'b1;
         STB_CONST_LO: strobe_d = 1'b0;
         STB_PWM:      strobe_d = pwm_wave;
         STB_TRIG_HI,
         STB_FREE_HI:  strobe_d = pulse_on;
         STB_TRIG_LO,
         STB_FREE_LO:  strobe_d = ~pulse_on;
         default:      strobe_d = 1'b0;
      endcase
   end

   // Pins: PWM routing forces output
   assign pin_drv[0] = set_pwm_routing_in[0] ? pwm_wave : lvl_q[0];
   assign pin_drv[1] = set_pwm_routing_in[1] ? pwm_wave : lvl_q[1];
   assign sel_dir    = dir_q[pin_select_in];
   assign sel_lvl    = dir_q[pin_select_in] ? lvl_q[pin_select_in] : gpio_pin_in[pin_select_in];

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         dir_q <= 2'h0;
         lvl_q <= 2'h0;
      end else if (pin_cfg_wr_in) begin
         dir_q[pin_select_in] <= pin_direction_cfg_in;
         lvl_q[pin_select_in] <= pin_level_in;
      end
   end

   // Lamp state
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         lamp_q <= LAMP_RESET;
      end else if (lamp_set_in) begin
         lamp_q <= lamp_green_in;
      end else if (lamp_toggle_cmd_in) begin
         lamp_q <= ~lamp_q;
      end
   end

   // Registered outputs
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         strobe_out              <= 1'b0;
         gpio_pin_out            <= 2'h0;
         gpio_pin_oe_out         <= 2'h0;
         pin_capability_mask_out <= 2'h0;
         pin_direction_cfg_out   <= 1'b0;
         pin_level_out           <= 1'b0;
         pwm_pin_caps_out        <= 2'h0;
         pwm_freq_cur_out        <= 32'h0;
         pwm_freq_min_out        <= 32'h0;
         pwm_freq_max_out        <= 32'h0;
         pwm_freq_inc_out        <= 32'h0;
         pwm_duty_cur_out        <= 16'h0;
         pwm_duty_min_out        <= 16'h0;
         pwm_duty_max_out        <= 16'h0;
         pwm_duty_inc_out        <= 16'h0;
         pwm_routing_out         <= 2'h0;
         lamp_green_out          <= 1'b0;
         lamp_orange_out         <= 1'b0;
      end else begin
         strobe_out              <= strobe_d;
         gpio_pin_out            <= pin_drv;
         gpio_pin_oe_out         <= dir_q | set_pwm_routing_in;
         pin_capability_mask_out <= PIN_CAP_MASK;
         pin_direction_cfg_out   <= sel_dir;
         pin_level_out           <= sel_lvl;
         pwm_pin_caps_out        <= PWM_PIN_CAPS;
         pwm_freq_cur_out        <= pwm_frequency_in;
         pwm_freq_min_out        <= PWM_FREQ_MIN_HZ;
         pwm_freq_max_out        <= PWM_FREQ_MAX_HZ;
         pwm_freq_inc_out        <= PWM_FREQ_INC_HZ;
         pwm_duty_cur_out        <= pwm_duty_in;
         pwm_duty_min_out        <= DUTY_MIN;
         pwm_duty_max_out        <= DUTY_FULL;
         pwm_duty_inc_out        <= DUTY_INC;
         pwm_routing_out         <= set_pwm_routing_in;
         lamp_green_out          <= lamp_q;
         lamp_orange_out         <= ~lamp_q;
      end
   end
endmodule : csp_top

// [rtl/csp_pkg.sv]
/*
 Package for the camera strobe, PWM, general-purpose pin and lamp unit.
 Assumes a single 250 MHz clock and a synchronous active-high reset.
*/
package csp_pkg;
   localparam int unsigned CLK_FREQ_HZ      = 250000000;
   localparam int unsigned US_PER_S         = 1000000;
   localparam int unsigned TICK_DIV         = CLK_FREQ_HZ / US_PER_S;
   localparam logic [7:0]  TICK_DIV_LAST    = 8'(TICK_DIV - 1);
   localparam logic [31:0] PWM_FREQ_MIN_HZ  = 32'h0000_0001;
   localparam logic [31:0] PWM_FREQ_MAX_HZ  = 32'h0000_2710;
   localparam logic [31:0] PWM_FREQ_INC_HZ  = 32'h0000_0001;
   localparam logic [15:0] DUTY_MIN         = 16'h0000;
   localparam logic [15:0] DUTY_FULL        = 16'h8000;
   localparam logic [15:0] DUTY_INC         = 16'h0001;
   localparam logic [31:0] STB_DELAY_MIN_US = 32'h0000_0000;
   localparam logic [31:0] STB_DELAY_MAX_US = 32'h7FFF_FFFF;
   localparam logic [31:0] STB_LEN_MIN_US   = 32'h0000_0000;
   localparam logic [31:0] STB_LEN_MAX_US   = 32'hFFFF_FFFF;
   localparam logic [31:0] STB_INC_US       = 32'h0000_0001;
   localparam logic [31:0] STB_PIN_MIN_US   = 32'h0000_0014;
   localparam logic [31:0] STB_GPIO_MIN_US  = 32'h0000_0001;
   localparam logic [1:0]  PIN_CAP_INPUT    = 2'h1;
   localparam logic [1:0]  PIN_CAP_OUTPUT   = 2'h2;
   localparam logic [1:0]  PIN_CAP_MASK     = PIN_CAP_INPUT | PIN_CAP_OUTPUT;
   localparam logic [1:0]  PWM_PIN_CAPS     = 2'h3;
   localparam logic        LAMP_RESET       = 1'b0;

   typedef enum logic [2:0] {
      STB_OFF         = 3'h0,
      STB_TRIG_LO     = 3'h1,
      STB_TRIG_HI     = 3'h2,
      STB_CONST_HI    = 3'h3,
      STB_CONST_LO    = 3'h4,
      STB_FREE_LO     = 3'h5,
      STB_FREE_HI     = 3'h6,
      STB_PWM         = 3'h7
   } csp_strobe_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_DELAY = 3'b010,
      ST_PULSE = 3'b100
   } csp_stb_state_t;
endpackage : csp_pkg

// [rtl/csp_pwm.sv]
/*
 PWM waveform generator with frequency in hertz and duty in 1/32768 units.
 Clamps frequency into the 1 Hz to 10000 Hz range itself; duty at or above full gives always high.
*/
module csp_pwm
   import csp_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        sys_rst_in,
   // Settings
   input  wire logic [31:0] freq_hz_in,
   input  wire logic [15:0] duty_in,
   // Waveform
   output logic             pwm_out
);
   logic [31:0] period;
   logic [47:0] high_full;
   logic [31:0] high_cnt;
   logic [31:0] cnt_q;
   logic [31:0] freq_c;

   assign freq_c    = (freq_hz_in < PWM_FREQ_MIN_HZ) ? PWM_FREQ_MIN_HZ :
                      (freq_hz_in > PWM_FREQ_MAX_HZ) ? PWM_FREQ_MAX_HZ : freq_hz_in;
   assign period    = 32'(CLK_FREQ_HZ) / freq_c;
   assign high_full = 48'(period) * 48'(duty_in);
   assign high_cnt  = (duty_in >= DUTY_FULL) ? period : high_full[46:15];

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in || cnt_q >= period - 32'h1) begin
         cnt_q <= 32'h0;
      end else begin
         cnt_q <= cnt_q + 32'h1;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         pwm_out <= 1'b0;
      end else begin
         pwm_out <= (cnt_q < high_cnt);
      end
   end
endmodule : csp_pwm

// [tb/csp_assertions.sv]
/*
 Port checker for csp_top.
 Assumes one clock, a synchronous active-high reset and a bind by name.
*/
module csp_checker
   import csp_pkg::*;
(
   // Clock and reset
   input  wire logic                      ref_clk_in,
   input  wire logic                      sys_rst_in,
   // Design inputs
   input  wire logic                      expo_start_in,
   input  wire logic                      expo_end_in,
   input  wire logic                      global_start_shutter_in,
   input  wire logic                      trigger_mode_in,
   input  wire csp_pkg::csp_strobe_mode_t strobe_mode_in,
   input  wire logic signed [31:0]        strobe_delay_us_in,
   input  wire logic [31:0]               strobe_length_us_in,
   input  wire logic [15:0]               pwm_duty_in,
   input  wire logic [1:0]                set_pwm_routing_in,
   input  wire logic                      pin_cfg_wr_in,
   input  wire logic                      pin_direction_cfg_in,
   input  wire logic                      lamp_set_in,
   input  wire logic                      lamp_green_in,
   input  wire logic                      lamp_toggle_cmd_in,
   // Design outputs
   input  wire logic                      strobe_out,
   input  wire logic [1:0]                gpio_pin_out,
   input  wire logic [1:0]                gpio_pin_oe_out,
   input  wire logic [1:0]                pin_capability_mask_out,
   input  wire logic                      pin_direction_cfg_out,
   input  wire logic [31:0]               pwm_freq_max_out,
   input  wire logic                      lamp_green_out,
   input  wire logic                      lamp_orange_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] up_q;
   logic       up;
   logic       zl;
   assign up = up_q == 2'h3;
   assign zl = strobe_mode_in == STB_TRIG_HI && strobe_length_us_in == 32'h0 && !global_start_shutter_in;
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) up_q <= 2'h0;
      else if (!up) up_q <= up_q + 2'h1;
   end
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   a_lamp_pair: assert property (up |-> lamp_green_out != lamp_orange_out)
      else $error("lamp colours not complementary");
   a_lamp_set: assert property (lamp_set_in && up |-> ##2 lamp_green_out == $past(lamp_green_in, 2))
      else $error("lamp set not taken");
   a_lamp_toggle: assert property (lamp_toggle_cmd_in && !lamp_set_in && up
      |-> ##2 lamp_green_out != $past(lamp_green_out, 2)) else $error("lamp toggle not taken");
   a_pin_readback: assert property (pin_cfg_wr_in && up
      |-> ##2 pin_direction_cfg_out == $past(pin_direction_cfg_in, 2)) else $error("pin direction readback");
   a_caps_fixed: assert property (up |-> pin_capability_mask_out == 2'h3 && pwm_freq_max_out == 32'h2710)
      else $error("capability readback");
   a_const_level: assert property (up && strobe_mode_in inside {STB_CONST_HI, STB_CONST_LO}
      && $past(strobe_mode_in, 3) == strobe_mode_in |-> strobe_out == (strobe_mode_in == STB_CONST_HI))
      else $error("constant strobe level");
   a_strobe_launch: assert property (up && expo_start_in && strobe_mode_in == STB_TRIG_HI && trigger_mode_in
      && strobe_delay_us_in == 32'sh0 && !strobe_out |-> ##1 !strobe_out ##1 strobe_out)
      else $error("strobe launch timing");
   a_zero_hold: assert property (strobe_out && zl && !expo_end_in && !$past(expo_end_in)
      && !$past(expo_end_in, 2) |=> strobe_out) else $error("zero length strobe dropped early");
   a_zero_end: assert property (expo_end_in && strobe_out && zl |-> ##3 !strobe_out)
      else $error("zero length strobe held past end");
   a_pwm_route: assert property ((strobe_mode_in == STB_PWM && pwm_duty_in == DUTY_FULL) [*8] |-> strobe_out)
      else $error("full duty not on strobe");
   a_pwm_pin: assert property ((set_pwm_routing_in[1] && pwm_duty_in == DUTY_FULL) [*8]
      |-> gpio_pin_out[1] && gpio_pin_oe_out[1]) else $error("full duty not on pin 2");
endmodule : csp_checker

bind csp_top csp_checker u_chk (
   .ref_clk_in              (ref_clk_in),
   .sys_rst_in              (sys_rst_in),
   .expo_start_in           (expo_start_in),
   .expo_end_in             (expo_end_in),
   .global_start_shutter_in (global_start_shutter_in),
   .trigger_mode_in         (trigger_mode_in),
   .strobe_mode_in          (strobe_mode_in),
   .strobe_delay_us_in      (strobe_delay_us_in),
   .strobe_length_us_in     (strobe_length_us_in),
   .pwm_duty_in             (pwm_duty_in),
   .set_pwm_routing_in      (set_pwm_routing_in),
   .pin_cfg_wr_in           (pin_cfg_wr_in),
   .pin_direction_cfg_in    (pin_direction_cfg_in),
   .lamp_set_in             (lamp_set_in),
   .lamp_green_in           (lamp_green_in),
   .lamp_toggle_cmd_in      (lamp_toggle_cmd_in),
   .strobe_out              (strobe_out),
   .gpio_pin_out            (gpio_pin_out),
   .gpio_pin_oe_out         (gpio_pin_oe_out),
   .pin_capability_mask_out (pin_capability_mask_out),
   .pin_direction_cfg_out   (pin_direction_cfg_out),
   .pwm_freq_max_out        (pwm_freq_max_out),
   .lamp_green_out          (lamp_green_out),
   .lamp_orange_out         (lamp_orange_out)
);

// [tb/csp_pin_model.sv]
/*
 Equipment on the two general-purpose pins.
 Assumes the design's enable is high while it drives a pin.
*/
module csp_pin_model (
   // Design side
   input  wire logic [1:0] pin_oe_in,
   input  wire logic [1:0] pin_drv_in,
   // Equipment level when released
   input  wire logic [1:0] ext_level_in,
   output logic [1:0]      pin_level_out
);
   timeunit 1ns;
   timeprecision 1ps;
   assign pin_level_out = (pin_oe_in & pin_drv_in) | (~pin_oe_in & ext_level_in);
endmodule : csp_pin_model

// [tb/camera_strobe_pwm_gpio_io_tb.sv]
/*
 Bench for csp_top: lamp, pins, strobe and PWM.
 Assumes csp_pin_model on the pins and the bound checker.
*/
module camera_strobe_pwm_gpio_io_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import csp_pkg::*;
   logic ref_clk_in = 0, sys_rst_in = 1, expo_start_in = 0, expo_end_in = 0, first_row_end_in = 0;
   logic global_start_shutter_in = 0, trigger_mode_in = 1, pin_select_in = 0, pin_cfg_wr_in = 0;
   logic pin_direction_cfg_in = 0, pin_level_in = 0, lamp_set_in = 0, lamp_green_in = 0, lamp_toggle_cmd_in = 0;
   csp_strobe_mode_t   strobe_mode_in = STB_OFF;
   logic signed [31:0] strobe_delay_us_in = 0;
   logic [31:0]        strobe_length_us_in = 0, pwm_frequency_in = 32'h2710;
   logic [15:0]        pwm_duty_in = 16'h8000;
   logic [1:0]         set_pwm_routing_in = 0, gpio_pin_in, ext_lvl = 0;
   logic               strobe_out, pin_direction_cfg_out, pin_level_out, lamp_green_out, lamp_orange_out;
   logic [1:0]         gpio_pin_out, gpio_pin_oe_out, pin_capability_mask_out, pwm_pin_caps_out, pwm_routing_out;
   logic [31:0]        pwm_freq_cur_out, pwm_freq_min_out, pwm_freq_max_out, pwm_freq_inc_out;
   logic [15:0]        pwm_duty_cur_out, pwm_duty_min_out, pwm_duty_max_out, pwm_duty_inc_out;
   int                 err_count = 0, check_count = 0, s, w;
   csp_top u_dut (.*);
   csp_pin_model u_pins (.pin_oe_in(gpio_pin_oe_out), .pin_drv_in(gpio_pin_out), .ext_level_in(ext_lvl),
      .pin_level_out(gpio_pin_in));
   always #2 ref_clk_in = ~ref_clk_in;
   task automatic chk(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'h1) begin
         err_count++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask : chk
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_in);
   endtask : cyc
   task automatic pulse_start;
      expo_start_in = 1;
      cyc(1);
      expo_start_in = 0;
   endtask : pulse_start
   task automatic wt(input logic v, output int c);
      for (c = 0; c < 30000 && strobe_out !== v; c++) cyc(1);
      if (c == 30000) begin
         chk(0, "strobe wait");
         conclude;
      end
   endtask : wt
   task automatic lamp(input logic st, g, t, e);
      lamp_set_in = st;
      lamp_green_in = g;
      lamp_toggle_cmd_in = t;
      cyc(1);
      lamp_set_in = 0;
      lamp_toggle_cmd_in = 0;
      cyc(3);
      chk(lamp_green_out === e && lamp_orange_out === !e, "lamp colour");
   endtask : lamp
   task automatic pin(input logic sel, dir, lvl, input logic [1:0] ext);
      pin_select_in = sel;
      pin_direction_cfg_in = dir;
      pin_level_in = lvl;
      ext_lvl = ext;
      pin_cfg_wr_in = 1;
      cyc(1);
      pin_cfg_wr_in = 0;
      cyc(4);
   endtask : pin
   task automatic expo(input csp_strobe_mode_t m, input logic act);
      strobe_mode_in = m;
      trigger_mode_in = m inside {STB_TRIG_LO, STB_TRIG_HI};
      strobe_delay_us_in = 32'sh14;
      strobe_length_us_in = 32'h14;
      cyc(4);
      chk(strobe_out === !act, "idle level");
      pulse_start;
      wt(act, s);
      wt(!act, w);
      chk(s >= 4995 && s <= 5255, "delay");
      chk(w >= 4749 && w <= 5251, "length");
   endtask : expo
   initial begin
      cyc(2);
      sys_rst_in = 0;
      cyc(3);
      chk(lamp_orange_out === 1'h1 && lamp_green_out === 1'h0, "lamp reset");
      chk(pin_capability_mask_out === 2'h3 && pwm_pin_caps_out === 2'h3, "caps");
      chk({pwm_freq_min_out, pwm_freq_max_out, pwm_freq_inc_out} === {32'h1, 32'h2710, 32'h1}, "freq");
      chk({pwm_duty_min_out, pwm_duty_max_out, pwm_duty_inc_out} === {16'h0, DUTY_FULL, 16'h1}, "duty");
      lamp(1, 1, 0, 1);
      lamp(0, 0, 1, 0);
      lamp(0, 0, 1, 1);
      lamp(1, 0, 1, 0);
      pin(0, 1, 1, 2'h0);
      chk(gpio_pin_oe_out === 2'h1 && gpio_pin_out[0] === 1'h1 && pin_level_out === 1'h1, "pin1 high");
      chk(pin_direction_cfg_out === 1'h1, "pin1 dir");
      pin(1, 0, 0, 2'h2);
      chk(pin_direction_cfg_out === 1'h0 && gpio_pin_oe_out[1] === 1'h0 && pin_level_out === 1'h1, "pin2");
      ext_lvl = 2'h0;
      cyc(4);
      chk(pin_level_out === 1'h0, "pin2 low");
      pin(0, 1, 0, 2'h0);
      chk(gpio_pin_out[0] === 1'h0 && pin_level_out === 1'h0, "pin1 low");
      strobe_mode_in = STB_TRIG_HI;
      for (int g = 0; g < 2; g++) begin
         global_start_shutter_in = g[0];
         strobe_delay_us_in = -g;
         cyc(4);
         pulse_start;
         cyc(20);
         chk(strobe_out === 1'h1, "hold");
         expo_end_in = 1;
         cyc(1);
         expo_end_in = 0;
         cyc(4);
         chk(strobe_out === g[0], "end event");
         first_row_end_in = 1;
         cyc(1);
         first_row_end_in = 0;
         cyc(4);
         chk(strobe_out === 1'h0, "row end");
      end
      global_start_shutter_in = 0;
      strobe_mode_in = STB_CONST_HI;
      cyc(4);
      chk(strobe_out === 1'h1, "const high");
      strobe_mode_in = STB_CONST_LO;
      cyc(4);
      chk(strobe_out === 1'h0, "const low");
      expo(STB_TRIG_HI, 1);
      expo(STB_TRIG_LO, 0);
      expo(STB_FREE_HI, 1);
      expo(STB_FREE_LO, 0);
      strobe_mode_in = STB_PWM;
      set_pwm_routing_in = 2'h3;
      cyc(12);
      chk(strobe_out === 1'h1 && gpio_pin_out === 2'h3 && gpio_pin_oe_out === 2'h3, "full");
      chk(pwm_routing_out === 2'h3 && pwm_freq_cur_out === 32'h2710 && pwm_duty_cur_out === 16'h8000, "cur");
      pwm_duty_in = 16'h4000;
      wt(0, w);
      wt(1, w);
      wt(0, s);
      wt(1, w);
      chk(s >= 12400 && s <= 12600, "half duty");
      chk(s + w == 25000, "pwm period");
      conclude;
   end
endmodule : camera_strobe_pwm_gpio_io_tb
